// ---- rtl/pomc_pkg.sv ----
// Purpose: constants for the operating mode configuration block
// Assumes: AHB-Lite word access, four ports
// Notes: byte addresses, field positions, reset values and command words
package pomc_pkg;

   // ***************************************************
   // geometry
   // ***************************************************
   localparam int NPORTS = 4;
   localparam int REG_W = 16;

   // ***************************************************
   // address map (byte addresses)
   // ***************************************************
   localparam int ADDR_GLOBAL_BIT = 7;      // 1 = global space
   localparam int ADDR_PORT_HI = 6;
   localparam int ADDR_PORT_LO = 5;
   localparam int ADDR_REG_HI = 4;
   localparam int ADDR_REG_LO = 2;
   localparam logic [2:0] PREG_CTRL = 3'h0;   // port base + 0x00
   localparam logic [2:0] PREG_EXT = 3'h1;    // port base + 0x04
   localparam logic [2:0] PREG_STAT = 3'h2;   // port base + 0x08
   localparam logic [7:0] GREG_CMD = 8'h80;
   localparam logic [7:0] GREG_MACSEL = 8'h84;
   localparam logic [7:0] GREG_BCAST = 8'h88;
   localparam logic [7:0] GREG_APPLIED = 8'h8C;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int CTRL_SRST_BIT = 15;
   localparam int CTRL_ANEG_BIT = 12;
   localparam int EXT_MACPROT_BIT = 12;
   localparam int EXT_PREF_BIT = 11;
   localparam int EXT_AMS_BIT = 10;
   localparam int EXT_MEDIA_HI = 10;
   localparam int EXT_MEDIA_LO = 8;
   localparam int MACSEL_HI = 15;
   localparam int MACSEL_LO = 14;
   localparam int STAT_MEDIA_HI = 7;
   localparam int STAT_MEDIA_LO = 6;
   localparam int BCAST_EN_BIT = 0;
   localparam int CMD_MASK_HI = 11;
   localparam int CMD_MASK_LO = 8;

   // ***************************************************
   // encodings and reset values
   // ***************************************************
   localparam logic [1:0] MACSEL_SGMII = 2'h0;
   localparam logic [1:0] MACSEL_QSGMII = 2'h1;
   localparam logic [2:0] MEDIA_1000X = 3'h2;
   localparam logic [2:0] MEDIA_100FX = 3'h3;
   localparam logic [15:0] CMD_MAC_CFG = 16'h80F0;
   localparam logic [3:0] CMD_PREFIX = 4'h8;
   localparam logic [7:0] CMD_OP_1000X = 8'hC1;
   localparam logic [7:0] CMD_OP_100FX = 8'hD1;
   localparam logic [3:0] QSGMII_PORT_MASK = 4'h1;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [4:0] EXT_RST = 5'h00;
   localparam logic [1:0] MACSEL_RST = 2'h0;
   localparam logic [15:0] CMD_RST = 16'h0000;

endpackage

// ---- rtl/pomc_port_if.sv ----
// Purpose: carrier between the register front end and one port mode holder
// Assumes: single clock hclk
// Notes: strobes are one-cycle pulses from the front end
`timescale 1ns/10ps
interface pomc_port_if;
   logic wr_ctrl;
   logic rd_ctrl;
   logic wr_ext;
   logic [15:0] wdata;
   logic media_set;
   logic [2:0] media_mode;
   logic mac_clr;
   logic qsgmii;
   logic [15:0] ctrl_rd;
   logic [15:0] ext_rd;
   logic srst_pulse;
   logic app_aneg;
   logic app_macprot;
   logic [2:0] app_media;
   logic app_ams;
   logic app_pref;

   modport front (
      output wr_ctrl, rd_ctrl, wr_ext, wdata, media_set, media_mode, mac_clr, qsgmii,
      input ctrl_rd, ext_rd, srst_pulse, app_aneg, app_macprot, app_media, app_ams, app_pref
   );
   modport port (
      input wr_ctrl, rd_ctrl, wr_ext, wdata, media_set, media_mode, mac_clr, qsgmii,
      output ctrl_rd, ext_rd, srst_pulse, app_aneg, app_macprot, app_media, app_ams, app_pref
   );
endinterface // pomc_port_if

// ---- rtl/pomc_port.sv ----
// Purpose: per-port mode fields, software reset bit and applied mode copy
// Assumes: strobes from pomc_top, same clock
// Notes: applied copy changes only on this port's software reset
`timescale 1ns/10ps
module pomc_port #(
   parameter int PORT_IDX = 0
) (
   input wire logic hclk,
   input wire logic hresetn,
   pomc_port_if.port pif
);

   logic aneg_q;
   logic srst_q;
   logic [4:0] ext_q;          // {macprot, pref, media[2:0]}
   logic srst_pulse_q;
   logic app_aneg_q;
   logic [4:0] app_ext_q;
   logic srst_req;

   assign srst_req = pif.wr_ctrl & pif.wdata[pomc_pkg::CTRL_SRST_BIT];

   // control fields: autoneg enable and read-cleared reset bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aneg_q <= pomc_pkg::CTRL_RST[pomc_pkg::CTRL_ANEG_BIT];
         srst_q <= pomc_pkg::CTRL_RST[pomc_pkg::CTRL_SRST_BIT];
      end else begin
         if (pif.wr_ctrl) begin
            aneg_q <= pif.wdata[pomc_pkg::CTRL_ANEG_BIT];
         end
         if (srst_req) begin
            srst_q <= 1'b1;                 // set wins over read clear [R11]
         end else if (pif.rd_ctrl) begin
            srst_q <= 1'b0;                 // cleared by read [R12]
         end
      end
   end

   // extended control: protocol, preference, media mode, sense enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_q <= pomc_pkg::EXT_RST;
      end else begin
         if (pif.wr_ext) begin
            ext_q <= pif.wdata[pomc_pkg::EXT_MACPROT_BIT:pomc_pkg::EXT_MEDIA_LO]; // [R2] [R3] [R5] [R6] [R17]
         end else begin
            if (pif.media_set) begin
               ext_q[2:0] <= pif.media_mode;      // [R9] [R10]
            end
            if (pif.mac_clr) begin
               ext_q[4] <= 1'b0;                  // serial MAC needs protocol bit 0 [R2]
            end
         end
      end
   end

   // apply the held fields one cycle after the software reset pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         srst_pulse_q <= 1'b0;
         app_aneg_q <= pomc_pkg::CTRL_RST[pomc_pkg::CTRL_ANEG_BIT];
         app_ext_q <= pomc_pkg::EXT_RST;
      end else begin
         srst_pulse_q <= srst_req;
         if (srst_pulse_q) begin
            app_aneg_q <= aneg_q;                 // fields kept, only copied [R11] [R17]
            app_ext_q <= ext_q;
         end
      end
   end

   assign pif.ctrl_rd = {srst_q, 2'b00, aneg_q, 12'h000};
   assign pif.ext_rd = {3'b000, ext_q, 8'h00};
   assign pif.srst_pulse = srst_pulse_q;
   assign pif.app_aneg = app_aneg_q;
   assign pif.app_macprot = app_ext_q[4];
   assign pif.app_pref = app_ext_q[3];
   assign pif.app_media = app_ext_q[2:0];
   // in QSGMII only port 0 takes media sense
   assign pif.app_ams = app_ext_q[2] & (~pif.qsgmii | (PORT_IDX == 0)); // [R5] [R13]

endmodule // pomc_port

// ---- rtl/pomc_top.sv ----
// Purpose: operating mode configuration register bank with AHB-Lite slave
// Assumes: single word transfers, zero wait state, selected media fed from same clock
// Notes: mode settings reach the outputs only on a port software reset
//    port p at p*0x20: control +0x00, extended control +0x04, status +0x08
//    global: command 0x80, MAC select 0x84, broadcast 0x88, applied 0x8C
//    upper half of every word reads zero
//    reads see no wait state
//
// Operation
// R1: global MAC interface field 15:14 selects SGMII with 00 and QSGMII with 01.
// R2: per-port MAC protocol bit 12 of the extended control word is 0 for a serial MAC interface.
// R3: per-port media mode field 10:8 selects 1000BASE-X with 010 and 100BASE-FX with 011.
// R4: software sets autoneg bit 12 for 1000BASE-X partners and clears it for 100BASE-FX partners.
// R5: writing 1 to extended control bit 10 enables automatic media sense between fiber and copper.
// R6: extended control bit 11 holds the media preference used by automatic media sense.
// R7: the media chosen by automatic media sense reads back in status bits 7:6.
// R8: software writes command 0x80F0 to configure the serial MAC interface.
// R9: command 0x8FC1 sets 1000BASE-X media on the ports whose bit in nibble 11:8 is set.
// R10: command 0x8FD1 sets 100BASE-FX media on the ports selected by the same nibble.
// R11: a mode change takes effect only when software sets control bit 15 as a software reset.
// R12: reading the control word clears its software reset bit.
// R13: with a QSGMII MAC only port 0 takes fiber and media sense configuration; the code masks only media commands and media sense to port 0.
// R14: software gives every port the same MAC interface type.
// R15: the MAC select field is global and every other mode field is held per port.
// R16: with broadcast bit 0 set a per-port write reaches all ports at once.
// R17: mode fields keep their values until rewritten or hardware reset.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module pomc_top #(
   parameter int NPORTS = pomc_pkg::NPORTS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [2*NPORTS-1:0] media_selected_status,
   output logic [1:0] mac_if_select,
   output logic mac_cfg_pulse,
   output logic [NPORTS-1:0] port_soft_reset,
   output logic [NPORTS-1:0] port_aneg_en,
   output logic [NPORTS-1:0] port_mac_protocol,
   output logic [3*NPORTS-1:0] port_media_mode,
   output logic [NPORTS-1:0] port_automatic_media_sense,
   output logic [NPORTS-1:0] port_media_pref
);

   // ***************************************************
   // bus front end
   // ***************************************************
   logic dph_q;
   logic wr_q;
   logic [7:0] addr_q;
   logic wr_en;
   logic rd_en;
   logic glob;
   logic [1:0] port_sel;
   logic [2:0] preg;
   logic [15:0] wd;
   logic sel_cmd;
   logic sel_macsel;
   logic sel_bcast;

   // address phase capture, any size treated as a word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         dph_q <= hsel & htrans[1];
         wr_q <= hwrite;
         addr_q <= {haddr[7:2], 2'b00};
      end
   end

   // data phase decode
   assign wr_en = dph_q & wr_q;
   assign rd_en = dph_q & ~wr_q;
   assign glob = addr_q[pomc_pkg::ADDR_GLOBAL_BIT];
   assign port_sel = addr_q[pomc_pkg::ADDR_PORT_HI:pomc_pkg::ADDR_PORT_LO];
   assign preg = addr_q[pomc_pkg::ADDR_REG_HI:pomc_pkg::ADDR_REG_LO];
   assign wd = hwdata[15:0];

   // zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // global register selects
   assign sel_cmd = glob & (addr_q == pomc_pkg::GREG_CMD);
   assign sel_macsel = glob & (addr_q == pomc_pkg::GREG_MACSEL);
   assign sel_bcast = glob & (addr_q == pomc_pkg::GREG_BCAST);

   // ***************************************************
   // global registers
   // ***************************************************
   logic [1:0] macsel_q;
   logic [1:0] app_macsel_q;
   logic bcast_q;
   logic [15:0] cmd_q;
   logic mac_cfg_q;
   logic cmd_wr;
   logic cmd_media_hit;
   logic [2:0] cmd_media;
   logic [3:0] cmd_mask;
   logic qsgmii;
   logic any_srst;

   assign cmd_wr = wr_en & sel_cmd;

   // QSGMII counts only once applied
   assign qsgmii = (app_macsel_q == pomc_pkg::MACSEL_QSGMII);  // [R1]

   // ***************************************************
   // command decode
   // ***************************************************

   // media commands: prefix nibble and low byte
   always_comb begin
      cmd_media_hit = 1'b0;
      cmd_media = pomc_pkg::MEDIA_1000X;
      if (cmd_wr && wd[15:12] == pomc_pkg::CMD_PREFIX) begin
         if (wd[7:0] == pomc_pkg::CMD_OP_1000X) begin
            cmd_media_hit = 1'b1;                                 // [R9]
            cmd_media = pomc_pkg::MEDIA_1000X;
         end else if (wd[7:0] == pomc_pkg::CMD_OP_100FX) begin
            cmd_media_hit = 1'b1;                                 // [R10]
            cmd_media = pomc_pkg::MEDIA_100FX;
         end
      end
   end

   // port mask nibble, port 0 only with QSGMII
   always_comb begin
      cmd_mask = wd[pomc_pkg::CMD_MASK_HI:pomc_pkg::CMD_MASK_LO];
      if (qsgmii) begin
         cmd_mask = cmd_mask & pomc_pkg::QSGMII_PORT_MASK;        // [R13]
      end
   end

   // ***************************************************
   // global register storage
   // ***************************************************

   // global MAC select, written once for the device
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         macsel_q <= pomc_pkg::MACSEL_RST;
      end else if (wr_en && sel_macsel) begin
         macsel_q <= wd[pomc_pkg::MACSEL_HI:pomc_pkg::MACSEL_LO]; // [R1] [R15]
      end
   end

   // MAC select applied on any port's software reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         app_macsel_q <= pomc_pkg::MACSEL_RST;
      end else if (any_srst) begin
         app_macsel_q <= macsel_q;                                // [R11]
      end
   end

   // broadcast enable for per-port writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcast_q <= 1'b0;
      end else if (wr_en && sel_bcast) begin
         bcast_q <= wd[pomc_pkg::BCAST_EN_BIT];                   // [R16]
      end
   end

   // one-cycle pulse after a MAC configure command
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mac_cfg_q <= 1'b0;
      end else begin
         mac_cfg_q <= cmd_wr && (wd == pomc_pkg::CMD_MAC_CFG);    // [R8]
      end
   end

   // command word, reads back with bit 15 clear once executed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_q <= pomc_pkg::CMD_RST;
      end else if (cmd_wr) begin
         cmd_q <= {1'b0, wd[14:0]};
      end
   end

   // applied global outputs
   assign mac_if_select = app_macsel_q;
   assign mac_cfg_pulse = mac_cfg_q;

   // ***************************************************
   // port mode holders
   // ***************************************************
   pomc_port_if pif [NPORTS] ();
   logic [15:0] ctrl_rd [NPORTS];
   logic [15:0] ext_rd [NPORTS];
   logic [15:0] stat_rd [NPORTS];
   logic [NPORTS-1:0] srst_vec;

   genvar gi;
   generate
      for (gi = 0; gi < NPORTS; gi++) begin : g_port
         logic hit;
         logic rd_hit;
         // broadcast makes any port address reach every port
         assign hit = wr_en & ~glob & (bcast_q | (port_sel == 2'(gi))); // [R16] [R15]
         assign pif[gi].wr_ctrl = hit & (preg == pomc_pkg::PREG_CTRL);    // [R11]
         assign pif[gi].wr_ext = hit & (preg == pomc_pkg::PREG_EXT);
         // reads reach only the addressed port
         assign rd_hit = rd_en & ~glob & (port_sel == 2'(gi));
         assign pif[gi].rd_ctrl = rd_hit & (preg == pomc_pkg::PREG_CTRL); // [R12]
         assign pif[gi].wdata = wd;

         // command strobes and applied MAC type
         assign pif[gi].media_set = cmd_media_hit & cmd_mask[gi];         // [R9] [R10] [R13]
         assign pif[gi].media_mode = cmd_media;
         assign pif[gi].mac_clr = mac_cfg_q;                              // [R2]
         assign pif[gi].qsgmii = qsgmii;

         pomc_port #(
            .PORT_IDX(gi)
         ) u_port (
            .hclk(hclk),
            .hresetn(hresetn),
            .pif(pif[gi])
         );

         assign ctrl_rd[gi] = pif[gi].ctrl_rd;
         assign ext_rd[gi] = pif[gi].ext_rd;
         // status: selected media, applied autoneg and applied extended bits
         assign stat_rd[gi] = {8'h00,
                               media_selected_status[2*gi+1 -: 2],        // [R7]
                               pif[gi].app_aneg,
                               pif[gi].app_macprot,
                               pif[gi].app_pref,
                               pif[gi].app_media};
         assign srst_vec[gi] = pif[gi].srst_pulse;

         // applied mode to the output pins
         assign port_aneg_en[gi] = pif[gi].app_aneg;
         assign port_mac_protocol[gi] = pif[gi].app_macprot;
         assign port_media_mode[3*gi+2 -: 3] = pif[gi].app_media;         // [R3]
         assign port_automatic_media_sense[gi] = pif[gi].app_ams;         // [R5]
         assign port_media_pref[gi] = pif[gi].app_pref;                   // [R6]
      end
   endgenerate

   // ***************************************************
   // software reset fan-in
   // ***************************************************
   // any port's reset also applies the MAC select
   assign any_srst = |srst_vec;
   assign port_soft_reset = srst_vec;

   // ***************************************************
   // read data mux
   // ***************************************************
   logic [15:0] glob_rd;
   logic [15:0] port_rd;

   // global register read selection
   always_comb begin
      glob_rd = 16'h0000;
      case (addr_q)
         pomc_pkg::GREG_CMD: glob_rd = cmd_q;
         pomc_pkg::GREG_MACSEL: glob_rd = {macsel_q, 14'h0000};
         pomc_pkg::GREG_BCAST: glob_rd = {15'h0000, bcast_q};
         pomc_pkg::GREG_APPLIED: glob_rd = {app_macsel_q, 14'h0000};
         default: glob_rd = 16'h0000;
      endcase
   end

   // per-port read selection, unmapped reads zero
   always_comb begin
      port_rd = 16'h0000;
      if (port_sel < NPORTS) begin
         case (preg)
            pomc_pkg::PREG_CTRL: port_rd = ctrl_rd[port_sel];
            pomc_pkg::PREG_EXT: port_rd = ext_rd[port_sel];
            pomc_pkg::PREG_STAT: port_rd = stat_rd[port_sel];
            default: port_rd = 16'h0000;
         endcase
      end
   end

   // data only in a read data phase
   always_comb begin
      hrdata = 32'h00000000;
      if (rd_en) begin
         hrdata = {16'h0000, (glob ? glob_rd : port_rd)};
      end
   end

endmodule // pomc_top

// ---- bench/pomc_top_asserts.sv ----
// Purpose: concurrent checks on the mode configuration block ports
// Assumes: one clock hclk, hresetn async active low
// Notes: data phase tracked locally from the address phase
`timescale 1ns/10ps
module pomc_top_asserts #(
   parameter int NPORTS = pomc_pkg::NPORTS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic [2*NPORTS-1:0] media_selected_status,
   input wire logic [1:0] mac_if_select,
   input wire logic mac_cfg_pulse,
   input wire logic [NPORTS-1:0] port_soft_reset,
   input wire logic [NPORTS-1:0] port_aneg_en,
   input wire logic [3*NPORTS-1:0] port_media_mode,
   input wire logic [NPORTS-1:0] port_automatic_media_sense
);
   // ***************************************************
   // data phase tracking
   // ***************************************************
   logic dp_wr_q;
   logic dp_rd_q;
   logic [7:0] dp_addr_q;
   logic ctrl_srst_wr;
   logic mac_cmd_wr;
   logic stat_rd;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // remember the accepted address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_q <= 1'b0;
         dp_rd_q <= 1'b0;
         dp_addr_q <= 8'h00;
      end else begin
         dp_wr_q <= hsel && htrans[1] && hready && hwrite;
         dp_rd_q <= hsel && htrans[1] && hready && !hwrite;
         dp_addr_q <= haddr[7:0];
      end
   end

   // decoded data phase events
   assign ctrl_srst_wr = dp_wr_q && !dp_addr_q[7] && (dp_addr_q[4:2] == pomc_pkg::PREG_CTRL) && hwdata[15];
   assign mac_cmd_wr = dp_wr_q && (dp_addr_q == pomc_pkg::GREG_CMD) && (hwdata[15:0] == pomc_pkg::CMD_MAC_CFG);
   assign stat_rd = dp_rd_q && !dp_addr_q[7] && (dp_addr_q[4:2] == pomc_pkg::PREG_STAT);

   property p_srst_launch;
      ctrl_srst_wr |=> port_soft_reset[$past(dp_addr_q[6:5])];
   endproperty
   a_srst_launch: assert property (p_srst_launch)
      else $error("soft reset pulse missing after control write");
   property p_srst_cause;
      (|port_soft_reset) |-> $past(ctrl_srst_wr);
   endproperty
   a_srst_cause: assert property (p_srst_cause)
      else $error("soft reset pulse without control write");
   property p_apply_hold;
      !$past(|port_soft_reset) |-> $stable({port_aneg_en, port_media_mode, port_automatic_media_sense});
   endproperty
   a_apply_hold: assert property (p_apply_hold)
      else $error("applied port mode changed without soft reset");
   property p_mac_hold;
      !$past(|port_soft_reset) |-> $stable(mac_if_select);
   endproperty
   a_mac_hold: assert property (p_mac_hold)
      else $error("applied mac select changed without soft reset");
   property p_cfg_launch;
      mac_cmd_wr |=> mac_cfg_pulse;
   endproperty
   a_cfg_launch: assert property (p_cfg_launch)
      else $error("mac config pulse missing");
   property p_cfg_cause;
      mac_cfg_pulse |-> $past(mac_cmd_wr);
   endproperty
   a_cfg_cause: assert property (p_cfg_cause)
      else $error("mac config pulse without command");
   property p_stat_media;
      stat_rd |-> hrdata[7:6] == media_selected_status[2*dp_addr_q[6:5] +: 2];
   endproperty
   a_stat_media: assert property (p_stat_media)
      else $error("selected media readback wrong");
   property p_qsgmii_ams;
      (mac_if_select == pomc_pkg::MACSEL_QSGMII) |-> (port_automatic_media_sense[NPORTS-1:1] == '0);
   endproperty
   a_qsgmii_ams: assert property (p_qsgmii_ams)
      else $error("media sense active on non-zero port in qsgmii");
endmodule // pomc_top_asserts

// ---- bench/test_phy_operating_mode_config.sv ----
// Purpose: self-checking bench for the mode configuration block
// Assumes: AHB-Lite single word transfers, hready fed from hreadyout
// Notes: outputs sampled at rising edges before that edge's updates
`timescale 1ns/10ps
module test_phy_operating_mode_config;
   // ***************************************************
   // stimulus and checking
   // ***************************************************
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mac_cfg_pulse;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, mac_if_select;
   logic [2:0] hsize;
   logic [7:0] media_selected_status;
   logic [3:0] port_soft_reset, port_aneg_en, port_mac_protocol, port_automatic_media_sense, port_media_pref;
   logic [11:0] port_media_mode;
   logic [31:0] rd;
   int fail_count = 0;
   int check_count = 0;
   assign hready = hreadyout;

   pomc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .media_selected_status(media_selected_status),
      .mac_if_select(mac_if_select), .mac_cfg_pulse(mac_cfg_pulse), .port_soft_reset(port_soft_reset),
      .port_aneg_en(port_aneg_en), .port_mac_protocol(port_mac_protocol), .port_media_mode(port_media_mode),
      .port_automatic_media_sense(port_automatic_media_sense), .port_media_pref(port_media_pref));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one single transfer, held until hready is seen high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do begin @(posedge hclk); end while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge hclk); end while (hready !== 1'b1);
      rdat = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask

   task automatic t_reset;
      chk(32'({port_aneg_en, port_media_mode, port_automatic_media_sense, mac_if_select}), 32'h0);
      rchk(8'h00, 32'h0);
      rchk(8'h04, 32'h0);
      rchk(8'h84, 32'h0);
      wr(8'h9C, 32'h0000FFFF);
      rchk(8'h9C, 32'h0);
      $display("test reset done");
   endtask

   // media commands against a per-port model of the media field
   task automatic t_media_cmd;
      logic [15:0] cmds [3] = '{16'h83C1, 16'h8FC1, 16'h84D1};
      logic [31:0] m [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
      for (int c = 0; c < 3; c++) begin
         wr(pomc_pkg::GREG_CMD, {16'h0, cmds[c]});
         for (int p = 0; p < 4; p++) begin
            if (cmds[c][8+p]) m[p] = {21'h0, (cmds[c][7:0] == pomc_pkg::CMD_OP_1000X) ? pomc_pkg::MEDIA_1000X : pomc_pkg::MEDIA_100FX, 8'h00};
            rchk(8'(p * 32 + 4), m[p]);
         end
      end
      $display("test media commands done");
   endtask

   task automatic t_soft_reset;
      wr(8'h00, 32'h1000);
      repeat (3) @(posedge hclk);
      chk(32'(port_aneg_en), 32'h0);
      wr(8'h00, 32'h9000);
      @(posedge hclk);
      chk(32'(port_soft_reset), 32'h1);
      @(posedge hclk);
      chk(32'(port_aneg_en), 32'h1);
      chk(32'(port_media_mode[2:0]), 32'(pomc_pkg::MEDIA_1000X));
      rchk(8'h00, 32'h9000);
      rchk(8'h00, 32'h1000);
      rchk(8'h08, 32'hE2);
      media_selected_status <= 8'h00;
      rchk(8'h08, 32'h22);
      $display("test soft reset done");
   endtask

   task automatic t_ams;
      wr(8'h24, 32'h0C00);
      wr(8'h20, 32'h8000);
      @(posedge hclk);
      chk(32'(port_soft_reset), 32'h2);
      @(posedge hclk);
      chk(32'({port_automatic_media_sense[1], port_media_pref[1], port_media_mode[5:3]}), 32'h1C);
      $display("test media sense done");
   endtask

   task automatic t_broadcast;
      wr(pomc_pkg::GREG_BCAST, 32'h1);
      wr(8'h04, 32'h0A00);
      rchk(8'h64, 32'h0A00);
      wr(pomc_pkg::GREG_BCAST, 32'h0);
      wr(8'h44, 32'h0300);
      rchk(8'h24, 32'h0A00);
      $display("test broadcast done");
   endtask

   task automatic t_qsgmii;
      wr(pomc_pkg::GREG_MACSEL, 32'h4000);
      wr(8'h64, 32'h1200);
      chk(32'(mac_if_select), 32'h0);
      wr(pomc_pkg::GREG_CMD, 32'h80F0);
      @(posedge hclk);
      chk(32'(mac_cfg_pulse), 32'h1);
      rchk(8'h64, 32'h0200);
      wr(8'h60, 32'h8000);
      repeat (2) @(posedge hclk);
      chk(32'(mac_if_select), 32'(pomc_pkg::MACSEL_QSGMII));
      chk(32'({port_automatic_media_sense[1], port_mac_protocol[3]}), 32'h0);
      wr(pomc_pkg::GREG_CMD, 32'h8FD1);
      rchk(8'h04, 32'h0B00);
      rchk(8'h24, 32'h0A00);
      rchk(pomc_pkg::GREG_APPLIED, 32'h4000);
      $display("test qsgmii done");
   endtask

   // clock
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // watchdog against a hung transfer
   initial begin
      repeat (5000) @(posedge hclk);
      fail_count++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      media_selected_status = 8'h1B;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_media_cmd();
      t_soft_reset();
      t_ams();
      t_broadcast();
      t_qsgmii();
      tally_and_finish();
   end
endmodule // test_phy_operating_mode_config

bind pomc_top pomc_top_asserts #(.NPORTS(NPORTS)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hwdata, .hrdata, .media_selected_status, .mac_if_select, .mac_cfg_pulse, .port_soft_reset,
   .port_aneg_en, .port_media_mode, .port_automatic_media_sense);
